// >>> hw/gfx_pkg.sv
// Constants, carriers and state codes for the line draw / block fill engine.
// Assumes one clock; the control fields arrive from a register file elsewhere.
package gfx_pkg;
   localparam int          ACC_W     = 12;
   localparam int          LEN_W     = 12;
   localparam logic [11:0] ACC_MID   = 12'h800;
   localparam logic [3:0]  DEPTH_8   = 4'h2;
   localparam logic [3:0]  DEPTH_16  = 4'h4;
   localparam logic [3:0]  DEPTH_32  = 4'h6;
   localparam logic [3:0]  BE_ALL    = 4'hF;
   localparam logic [31:0] ADDR_RST  = 32'h0000_0000;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;

   typedef struct packed {
      logic       line_select;
      logic       dest_x_direction;
      logic       dest_y_direction;
      logic       background_select;
      logic       done_irq_enable;
      logic [3:0] pixel_depth;
   } accel_control_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0]  be;
   } mem_wr_t;

   typedef enum logic [2:0] {
      S_IDLE,
      S_FILL,
      S_LDRAW,
      S_LSTEP,
      S_DRAIN
   } eng_state_t;
endpackage : gfx_pkg

// >>> hw/wr_buffer.sv
// Two-entry write buffer between the engine and the memory port.
// Assumes producer and consumer share the clock; ready and valid on both sides.
module wr_buffer
   import gfx_pkg::*;
#(
   parameter int W = 68
) (
   // Clock and control
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   typedef struct packed {
      logic         v0;
      logic         v1;
      logic [W-1:0] e0;
      logic [W-1:0] e1;
   } buf_state_t;

   buf_state_t s_q, s_d;

   // Ready comes from a flop so a stall never forms a loop back to the engine
   assign in_ready  = ~s_q.v1;
   assign out_valid = s_q.v0;
   assign out_data  = s_q.e0;

   always_comb begin
      s_d = s_q;
      if (s_q.v0 && out_ready) begin
         s_d.e0 = s_q.e1;
         s_d.v0 = s_q.v1;
         s_d.v1 = 1'b0;
      end
      if (in_valid && !s_q.v1) begin
         if (!s_d.v0) begin
            s_d.e0 = in_data;
            s_d.v0 = 1'b1;
         end else begin
            s_d.e1 = in_data;
            s_d.v1 = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_buf_hold_word: assert property (ce && out_valid && !out_ready |=>
      out_valid && $stable(out_data))
      else $error("buffered word dropped or changed while stalled");
endmodule : wr_buffer

// >>> hw/line_fill_engine.sv
// Line draw and block fill engine writing word-wide, byte-masked writes to a frame buffer.
// Assumes the setup fields are held steady while ENABLE is high and that
// the memory port accepts a word whenever MEM_READY is high.
module line_fill_engine
   import gfx_pkg::*;
(
   // Clock, reset, enable
   input  wire logic             CLK,
   input  wire logic             RST_N,
   input  wire logic             CE,
   // Control
   input  wire accel_control_t   ACCEL_CONTROL,
   input  wire logic             START,
   output logic                  ENABLE,
   output logic                  DONE_IRQ,
   // Line setup
   input  wire logic [ACC_W-1:0] X_ACCUM_INIT,
   input  wire logic [ACC_W-1:0] Y_ACCUM_INIT,
   input  wire logic [ACC_W-1:0] X_STEP,
   input  wire logic [ACC_W-1:0] Y_STEP,
   input  wire logic [15:0]      PATTERN_BITS,
   input  wire logic [3:0]       PATTERN_LAST_BIT,
   // Destination setup
   input  wire logic [LEN_W-1:0] STRIDE_WORDS,
   input  wire logic [4:0]       FIRST_PIXEL_BIT,
   input  wire logic [4:0]       LAST_PIXEL_BIT,
   input  wire logic [31:0]      DEST_START_ADDR,
   input  wire logic [11:0]      DEST_WIDTH,
   input  wire logic [11:0]      DEST_HEIGHT,
   input  wire logic [31:0]      FOREGROUND_VALUE,
   input  wire logic [31:0]      BACKGROUND_VALUE,
   // Memory write port
   output logic                  MEM_VALID,
   input  wire logic             MEM_READY,
   output mem_wr_t               MEM_WR
);
   typedef struct packed {
      eng_state_t       st;
      logic             en;
      logic             irq;
      logic [31:0]      addr;
      logic [31:0]      row;
      logic [1:0]       off;
      logic [11:0]      wcnt;
      logic [11:0]      hcnt;
      logic [ACC_W-1:0] xacc;
      logic [ACC_W-1:0] yacc;
      logic [3:0]       pidx;
      logic [23:0]      xcnt;
   } eng_t;

   eng_t s_q, s_d;

   logic          push;
   logic          push_ready;
   mem_wr_t       push_wr;
   logic [2:0]    pix_bytes;
   logic [3:0]    pix_be;
   logic [31:0]   fg_word;
   logic [31:0]   bg_word;
   logic [31:0]   stride_bytes;
   logic [3:0]    first_be;
   logic [3:0]    last_be;
   logic [3:0]    fill_be;
   logic [2:0]    last_end;
   logic          pat_on;
   logic          fill_last_w;
   logic [ACC_W:0] xsum;
   logic [ACC_W:0] ysum;
   logic [2:0]    off_up;
   logic [2:0]    off_dn;

   // Bytes per pixel and word replication of a colour
   function automatic logic [31:0] rep(input logic [3:0] depth, input logic [31:0] v);
      logic [31:0] r;
      r = v;
      if (depth == DEPTH_8) begin
         r = {4{v[7:0]}};
      end else if (depth == DEPTH_16) begin
         r = {2{v[15:0]}};
      end
      return r;
   endfunction : rep

   always_comb begin
      pix_bytes = 3'd4;
      pix_be    = BE_ALL;
      if (ACCEL_CONTROL.pixel_depth == DEPTH_8) begin
         pix_bytes = 3'd1;
         pix_be    = 4'h1;
      end else if (ACCEL_CONTROL.pixel_depth == DEPTH_16) begin
         pix_bytes = 3'd2;
         pix_be    = 4'h3;
      end
   end

   assign fg_word      = rep(ACCEL_CONTROL.pixel_depth, FOREGROUND_VALUE);
   assign bg_word      = rep(ACCEL_CONTROL.pixel_depth, BACKGROUND_VALUE);
   assign stride_bytes = {{(30-LEN_W){1'b0}}, STRIDE_WORDS, 2'b00};

   // Partial word masks from the pixel bounds
   assign first_be    = BE_ALL << FIRST_PIXEL_BIT[4:3];
   assign last_end    = {1'b0, LAST_PIXEL_BIT[4:3]} + pix_bytes;
   assign last_be     = (last_end[2]) ? BE_ALL : ~(BE_ALL << last_end[1:0]);
   assign fill_last_w = (s_q.wcnt == DEST_WIDTH);
   assign fill_be     = ((s_q.wcnt == 12'h000) ? first_be : BE_ALL)
                        & (fill_last_w ? last_be : BE_ALL);

   // Pattern bit of the current line pixel
   assign pat_on = PATTERN_BITS[s_q.pidx];

   assign xsum   = {1'b0, s_q.xacc} + {1'b0, X_STEP};
   assign ysum   = {1'b0, s_q.yacc} + {1'b0, Y_STEP};
   assign off_up = {1'b0, s_q.off} + pix_bytes;
   assign off_dn = {1'b0, s_q.off} - pix_bytes;

   // Word offered to the buffer
   always_comb begin
      push         = 1'b0;
      push_wr.addr = s_q.addr;
      push_wr.data = fg_word;
      push_wr.be   = fill_be;
      if (s_q.st == S_FILL) begin
         push = 1'b1;
      end else if (s_q.st == S_LDRAW) begin
         push_wr.be = pix_be << s_q.off;
         if (pat_on) begin
            push = 1'b1;
         end else begin
            push_wr.data = bg_word;
            push         = ACCEL_CONTROL.background_select;
         end
      end
   end

   always_comb begin
      s_d = s_q;
      case (s_q.st)
         S_IDLE: begin
            if (START) begin
               s_d.en   = 1'b1;
               s_d.irq  = 1'b0;
               s_d.addr = DEST_START_ADDR;
               s_d.row  = DEST_START_ADDR;
               s_d.off  = FIRST_PIXEL_BIT[4:3];
               s_d.wcnt = 12'h000;
               s_d.hcnt = 12'h000;
               s_d.xacc = X_ACCUM_INIT;
               s_d.yacc = Y_ACCUM_INIT;
               s_d.pidx = 4'h0;
               s_d.xcnt = 24'h00_0000;
               s_d.st   = ACCEL_CONTROL.line_select ? S_LDRAW : S_FILL;
            end
         end
         S_FILL: begin
            if (push_ready) begin
               s_d.addr = s_q.addr + WORD_STEP;
               s_d.wcnt = s_q.wcnt + 12'h001;
               if (fill_last_w) begin
                  s_d.wcnt = 12'h000;
                  s_d.hcnt = s_q.hcnt + 12'h001;
                  s_d.row  = s_q.row + stride_bytes;
                  s_d.addr = s_q.row + stride_bytes;
                  if (s_q.hcnt == DEST_HEIGHT) begin
                     s_d.st = S_DRAIN;
                  end
               end
            end
         end
         S_LDRAW: begin
            // A transparent pixel moves on without a memory write
            if (push_ready || !push) begin
               s_d.st = S_LSTEP;
            end
         end
         S_LSTEP: begin
            s_d.xacc = xsum[ACC_W-1:0];
            s_d.yacc = ysum[ACC_W-1:0];
            if (xsum[ACC_W]) begin
               s_d.xcnt = s_q.xcnt + 24'h00_0001;
               if (ACCEL_CONTROL.dest_x_direction) begin
                  s_d.off = off_up[1:0];
                  if (off_up[2]) begin
                     s_d.addr = s_q.addr + WORD_STEP;
                  end
               end else begin
                  s_d.off = off_dn[1:0];
                  if (off_dn[2]) begin
                     s_d.addr = s_q.addr - WORD_STEP;
                  end
               end
            end
            if (ysum[ACC_W]) begin
               if (ACCEL_CONTROL.dest_y_direction) begin
                  s_d.addr = s_d.addr + stride_bytes;
               end else begin
                  s_d.addr = s_d.addr - stride_bytes;
               end
            end
            if (xsum[ACC_W] || ysum[ACC_W]) begin
               s_d.pidx = (s_q.pidx == PATTERN_LAST_BIT) ? 4'h0 : s_q.pidx + 4'h1;
               s_d.st   = S_LDRAW;
               if (xsum[ACC_W] && s_q.xcnt == {DEST_HEIGHT, DEST_WIDTH}) begin
                  s_d.st = S_DRAIN;
               end
            end
         end
         S_DRAIN: begin
            // Done only once the buffer has handed every word to memory
            if (!MEM_VALID) begin
               s_d.en  = 1'b0;
               s_d.irq = ACCEL_CONTROL.done_irq_enable;
               s_d.st  = S_IDLE;
            end
         end
         default: begin
            s_d.st = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         s_q      <= '0;
         s_q.st   <= S_IDLE;
         s_q.addr <= ADDR_RST;
         s_q.row  <= ADDR_RST;
      end else if (CE) begin
         s_q <= s_d;
      end
   end

   assign ENABLE   = s_q.en;
   assign DONE_IRQ = s_q.irq;

   wr_buffer #(
      .W ($bits(mem_wr_t))
   ) u_wr_buffer (
      .clk       (CLK),
      .rst_n     (RST_N),
      .ce        (CE),
      .in_valid  (push),
      .in_ready  (push_ready),
      .in_data   (push_wr),
      .out_valid (MEM_VALID),
      .out_ready (MEM_READY),
      .out_data  (MEM_WR)
   );

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   a_start_sets_en: assert property (CE && START && s_q.st == S_IDLE |=> ENABLE)
      else $error("start did not raise the enable bit");

   a_done_clears_en: assert property (CE && s_q.st == S_DRAIN && !MEM_VALID
      |=> !ENABLE && s_q.st == S_IDLE)
      else $error("enable bit not cleared after the last write");

   a_irq_gate: assert property ($rose(DONE_IRQ) |->
      $past(ACCEL_CONTROL.done_irq_enable) && $fell(ENABLE))
      else $error("done request raised without enable or completion");

   a_line_select: assert property (CE && START && s_q.st == S_IDLE
      |=> s_q.st == (ACCEL_CONTROL.line_select ? S_LDRAW : S_FILL))
      else $error("wrong operation chosen at start");

   a_fill_value: assert property (s_q.st == S_FILL |->
      push && push_wr.data == rep(ACCEL_CONTROL.pixel_depth, FOREGROUND_VALUE))
      else $error("fill word is not the foreground value");

   a_line_on_fg: assert property (s_q.st == S_LDRAW && pat_on |->
      push && push_wr.data == fg_word)
      else $error("pattern-on pixel not in foreground colour");

   a_bg_transp: assert property (s_q.st == S_LDRAW && !pat_on |->
      push == ACCEL_CONTROL.background_select && push_wr.data == bg_word)
      else $error("pattern-off pixel handled wrongly");

   a_stride_next: assert property (CE && s_q.st == S_FILL && push_ready && fill_last_w
      && s_q.hcnt != DEST_HEIGHT |=> s_q.addr == $past(s_q.row) + $past(stride_bytes))
      else $error("next scan line not one stride below");

   a_pattern_wrap: assert property (CE && s_q.st == S_LSTEP && s_q.pidx == PATTERN_LAST_BIT
      && (xsum[ACC_W] || ysum[ACC_W]) |=> s_q.pidx == 4'h0)
      else $error("pattern did not wrap after the last bit");

   a_first_mask: assert property (s_q.st == S_FILL && s_q.wcnt == 12'h000 |->
      (push_wr.be & ~first_be) == 4'h0)
      else $error("first word writes bytes before the first pixel");
endmodule : line_fill_engine

// >>> tb/frame_mem.sv
// Frame buffer memory model: records every accepted word, stalls at random.
// Assumes it shares CLK with the engine; CE gates acceptance as it does there.
module frame_mem
   import gfx_pkg::*;
(
   // Clock and stall control
   input  wire logic    CLK,
   input  wire logic    CE,
   input  wire logic    STALL_ON,
   // Write port
   input  wire logic    MEM_VALID,
   output logic         MEM_READY,
   input  wire mem_wr_t MEM_WR
);
   timeunit 1ns;
   timeprecision 1ps;
   mem_wr_t seen[$];
   int      seed = 89933;
   initial MEM_READY = 1'b1;
   always @(posedge CLK) begin
      if (CE && MEM_VALID && MEM_READY)
         seen.push_back(MEM_WR);
      // Ready dropped often enough to fill the two-entry buffer
      MEM_READY <= !STALL_ON || ({$random(seed)} % 3 == 0);
   end
endmodule : frame_mem

// >>> tb/testbench.sv
// Self-checking bench: random fills at each depth and patterned lines, X-only or diagonal.
// Assumes the frame_mem model; expected words are rebuilt from the setup.
module testbench;
   import gfx_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = 1'b0, RST_N = 1'b0, CE = 1'b1, START = 1'b0, STALL_ON = 1'b0;
   accel_control_t ACCEL_CONTROL = '0, cfg;
   logic [11:0] X_ACCUM_INIT = '0, Y_ACCUM_INIT = '0, X_STEP = '0, Y_STEP = '0;
   logic [15:0] PATTERN_BITS = '0;
   logic [3:0]  PATTERN_LAST_BIT = '0;
   logic [11:0] STRIDE_WORDS = '0, DEST_WIDTH = '0, DEST_HEIGHT = '0;
   logic [4:0]  FIRST_PIXEL_BIT = '0, LAST_PIXEL_BIT = '0;
   logic [31:0] DEST_START_ADDR = '0, FOREGROUND_VALUE = '0, BACKGROUND_VALUE = '0;
   logic ENABLE, DONE_IRQ, MEM_VALID, MEM_READY;
   mem_wr_t MEM_WR;
   mem_wr_t exp[$];
   int fails = 0, checked = 0, seed = 89933;

   line_fill_engine i_line_fill_engine (.CLK(CLK), .RST_N(RST_N), .CE(CE),
      .ACCEL_CONTROL(ACCEL_CONTROL), .START(START), .ENABLE(ENABLE),
      .DONE_IRQ(DONE_IRQ), .X_ACCUM_INIT(X_ACCUM_INIT), .Y_ACCUM_INIT(Y_ACCUM_INIT),
      .X_STEP(X_STEP), .Y_STEP(Y_STEP), .PATTERN_BITS(PATTERN_BITS),
      .PATTERN_LAST_BIT(PATTERN_LAST_BIT), .STRIDE_WORDS(STRIDE_WORDS),
      .FIRST_PIXEL_BIT(FIRST_PIXEL_BIT), .LAST_PIXEL_BIT(LAST_PIXEL_BIT),
      .DEST_START_ADDR(DEST_START_ADDR), .DEST_WIDTH(DEST_WIDTH),
      .DEST_HEIGHT(DEST_HEIGHT), .FOREGROUND_VALUE(FOREGROUND_VALUE),
      .BACKGROUND_VALUE(BACKGROUND_VALUE), .MEM_VALID(MEM_VALID),
      .MEM_READY(MEM_READY), .MEM_WR(MEM_WR));
   frame_mem i_frame_mem (.CLK(CLK), .CE(CE), .STALL_ON(STALL_ON),
      .MEM_VALID(MEM_VALID), .MEM_READY(MEM_READY), .MEM_WR(MEM_WR));

   initial begin
      forever #2.5 CLK = ~CLK;
   end

   task automatic check(input logic [67:0] got, input logic [67:0] want);
      checked++;
      if (got !== want) begin
         fails++;
         $display("MISMATCH t=%0t got %h want %h", $time, got, want);
      end
   endtask : check

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   function automatic int pbytes(input logic [3:0] d);
      return (d == DEPTH_8) ? 1 : (d == DEPTH_16) ? 2 : 4;
   endfunction : pbytes

   function automatic logic [31:0] rep(input logic [31:0] c, input logic [3:0] d);
      return (d == DEPTH_8) ? {4{c[7:0]}} : (d == DEPTH_16) ? {2{c[15:0]}} : c;
   endfunction : rep

   task automatic exp_fill;
      int nb;
      logic [3:0] b;
      nb = pbytes(cfg.pixel_depth);
      for (int l = 0; l <= int'(DEST_HEIGHT); l++)
         for (int k = 0; k <= int'(DEST_WIDTH); k++) begin
            b = BE_ALL;
            if (k == 0) b = b & (BE_ALL << FIRST_PIXEL_BIT[4:3]);
            if (k == int'(DEST_WIDTH)) b = b & 4'((1 << (LAST_PIXEL_BIT[4:3] + nb)) - 1);
            exp.push_back(mem_wr_t'{DEST_START_ADDR + 32'(l * STRIDE_WORDS * 4 + k * 4),
                          rep(FOREGROUND_VALUE, cfg.pixel_depth), b});
         end
   endtask : exp_fill

   task automatic exp_line;
      logic on;
      logic [31:0] a;
      a = DEST_START_ADDR;
      for (int i = 0; i <= int'(DEST_WIDTH); i++) begin
         on = PATTERN_BITS[i % (int'(PATTERN_LAST_BIT) + 1)];
         if (on || cfg.background_select)
            exp.push_back(mem_wr_t'{a, on ? FOREGROUND_VALUE : BACKGROUND_VALUE, BE_ALL});
         a = cfg.dest_x_direction ? a + 32'h0000_0004 : a - 32'h0000_0004;
         // Full Y increment carries on every step, so each pixel moves one line
         if (Y_STEP != 12'h000)
            a = cfg.dest_y_direction ? a + 32'(STRIDE_WORDS) * 4 : a - 32'(STRIDE_WORDS) * 4;
      end
   endtask : exp_line

   task automatic run_op;
      int t;
      ACCEL_CONTROL <= '0;
      @(posedge CLK);
      ACCEL_CONTROL <= cfg;
      @(posedge CLK);
      START <= 1'b1;
      @(posedge CLK);
      START <= 1'b1;
      #1 check(ENABLE, 1'b1);
      @(posedge CLK);
      START <= 1'b0;
      #1 check(DONE_IRQ, 1'b0);
      for (t = 0; t < 4000 && ENABLE !== 1'b0; t++) begin
         @(posedge CLK);
         CE <= ($random(seed) % 8 != 0);
         #1;
      end
      @(posedge CLK);
      CE <= 1'b1;
      check(ENABLE, 1'b0);
      check(DONE_IRQ, cfg.done_irq_enable);
      check(i_frame_mem.seen.size(), exp.size());
      foreach (exp[i])
         if (i < i_frame_mem.seen.size())
            check(i_frame_mem.seen[i], exp[i]);
      exp.delete();
      i_frame_mem.seen.delete();
   endtask : run_op

   initial begin
      #200000;
      fails++;
      close_out();
   end

   initial begin
      repeat (5) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      #1 check({ENABLE, MEM_VALID, DONE_IRQ}, 3'b000);
      for (int n = 0; n < 16; n++) begin
         @(posedge CLK);
         cfg = accel_control_t'($random(seed));
         cfg.line_select = (n % 4 == 3);
         cfg.pixel_depth = (n % 4 == 0) ? DEPTH_8 : (n % 4 == 1) ? DEPTH_16 : DEPTH_32;
         STALL_ON <= n[0];
         X_ACCUM_INIT <= ACC_MID;
         Y_ACCUM_INIT <= ACC_MID;
         X_STEP <= 12'hFFF;
         Y_STEP <= (n % 8 == 7) ? 12'hFFF : 12'h000;
         PATTERN_BITS <= 16'($random(seed));
         PATTERN_LAST_BIT <= (n == 3) ? 4'hF : 4'($random(seed));
         STRIDE_WORDS <= 12'({$random(seed)} % 64 + 8);
         DEST_START_ADDR <= 32'h0000_1000 + 32'({$random(seed)} % 256 * 4);
         FOREGROUND_VALUE <= $random(seed);
         BACKGROUND_VALUE <= $random(seed);
         DEST_WIDTH <= (n < 3) ? 12'h000 : 12'({$random(seed)} % 6);
         DEST_HEIGHT <= (cfg.line_select || n < 3) ? 12'h000 : 12'({$random(seed)} % 4);
         FIRST_PIXEL_BIT <= cfg.line_select ? 5'h00
            : 5'({$random(seed)} % (4 / pbytes(cfg.pixel_depth)) * pbytes(cfg.pixel_depth) * 8);
         LAST_PIXEL_BIT <= cfg.line_select ? 5'h00
            : 5'({$random(seed)} % (4 / pbytes(cfg.pixel_depth)) * pbytes(cfg.pixel_depth) * 8);
         @(posedge CLK);
         if (cfg.line_select)
            exp_line();
         else
            exp_fill();
         run_op();
      end
      close_out();
   end
endmodule : testbench
